/* File: dv/orc_far_end.sv */
// far-side logic model: samples the channel c pin and measures its clock
`timescale 1ns/10ps

module orc_far_end (
    // clock
    input  wire logic        aclk,
    // observed pin
    input  wire logic        pin_c,
    // measurements
    output logic [7:0]       period,
    output logic [15:0]      rises
);
    logic       prev_q;
    logic [7:0] cnt_q;

    initial begin
        prev_q = 1'b0;
        cnt_q  = 8'h00;
        period = 8'h00;
        rises  = 16'h0000;
    end

    // sampled on aclk like a receiving register; period in aclk cycles
    always @(posedge aclk) begin
        prev_q <= pin_c;
        if (pin_c && !prev_q) begin
            period <= cnt_q + 8'h01;
            cnt_q  <= 8'h00;
            rises  <= rises + 16'h0001;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

/* File: dv/overrange_flag_clock_out_mux_tb.sv */
// self-checking bench of the over-range flags and channel c clock mux
`timescale 1ns/10ps
`include "orc_regs.svh"

module overrange_flag_clock_out_mux_tb;
    import orc_pkg::*;
    logic         aclk;
    logic         aresetn;
    orc_axi_req_t req;
    orc_axi_rsp_t rsp;
    logic [11:0]  smp [3];
    orc_variant_t variant;
    logic [1:0]   strap;
    logic         pll_en;
    logic         pd;
    wire  [2:0]   flags;
    logic         ref_out;
    logic         irq;
    logic [7:0]   period;
    logic [15:0]  rises;
    int           fails;
    int           n_compared;

    orc_top orc_top_i (
        .aclk                         (aclk),
        .aresetn                      (aresetn),
        .axi_req                      (req),
        .axi_rsp                      (rsp),
        .sample_a                     (smp[0]),
        .sample_b                     (smp[1]),
        .sample_c                     (smp[2]),
        .device_variant               (variant),
        .clock_out_select             (strap),
        .pll_enable                   (pll_en),
        .power_down_pin               (pd),
        .overrange_flag_ch_a          (flags[0]),
        .overrange_flag_ch_b          (flags[1]),
        .overrange_flag_ch_c_or_clock (flags[2]),
        .pll_reference_output         (ref_out),
        .irq                          (irq)
    );

    orc_far_end orc_far_end_i (
        .aclk   (aclk),
        .pin_c  (flags[2]),
        .period (period),
        .rises  (rises)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared=%0d mismatches=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) break;
        end
        if (n == 40) begin
            fails++;
            tally_and_finish();
        end
        check(32'(rsp.bresp), 32'(`ORC_RESP_OKAY));
        req.bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        int n;
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        if (n == 40) begin
            fails++;
            tally_and_finish();
        end
        check(rsp.rdata, exp);
        check(32'(rsp.rresp), 32'(er));
        req.rready <= 1'b0;
        @(posedge aclk);
    endtask

    // one exceeding sample, then count the cycles the flag stays high
    task automatic pulse(input int ch, input logic [11:0] v, output int hi);
        hi = 0;
        smp[ch] <= v;
        @(posedge aclk);
        smp[ch] <= 12'h000;
        repeat (24) begin
            @(posedge aclk);
            if (flags[ch] === 1'b1) hi++;
        end
    endtask

    task automatic t_strap_clock();
        logic r0;
        check(32'(period), 32'h2);
        @(posedge aclk);
        r0 = ref_out;
        @(posedge aclk);
        check(32'(ref_out ^ r0), 32'h1);
        rd_chk(`ORC_OFF_STATE, 32'h56, `ORC_RESP_OKAY);
    endtask

    task automatic t_regs_and_irq();
        int hi;
        rd_chk(`ORC_OFF_THRESH, 32'h700, `ORC_RESP_OKAY);
        rd_chk(`ORC_OFF_PLEN, 32'h4, `ORC_RESP_OKAY);
        rd_chk(8'h40, 32'h0, `ORC_RESP_SLVERR);
        wr(`ORC_OFF_THRESH, 32'h100);
        wr(`ORC_OFF_PLEN, 32'h3);
        pulse(0, 12'h100, hi);
        check(32'(hi), 32'h0);
        pulse(0, 12'hd00, hi);
        check(32'(hi), 32'h3);
        check(32'(flags[0]), 32'h0);
        check(32'(irq), 32'h0);
        wr(`ORC_OFF_MASK, 32'h7);
        check(32'(irq), 32'h1);
        rd_chk(`ORC_OFF_STATUS, 32'h1, `ORC_RESP_OKAY);
        check(32'(irq), 32'h0);
    endtask

    task automatic t_variants();
        int hi;
        // override with select 0 hands the pin back to flag c
        wr(`ORC_OFF_CLKCTL, 32'h1);
        rd_chk(`ORC_OFF_CLKCTL, 32'h1, `ORC_RESP_OKAY);
        for (int v = 0; v < 3; v++) begin
            variant <= orc_variant_t'(v);
            @(posedge aclk);
            pulse(1, 12'h7ff, hi);
            check(32'(hi), (v == 0) ? 32'h0 : 32'h3);
            pulse(2, 12'h801, hi);
            check(32'(hi), (v == 2) ? 32'h3 : 32'h0);
        end
        rd_chk(`ORC_OFF_STATUS, 32'h6, `ORC_RESP_OKAY);
    endtask

    task automatic t_clock_select();
        logic [15:0] n0;
        // descending so no step inherits the previous period
        for (int s = 3; s > 0; s--) begin
            wr(`ORC_OFF_CLKCTL, 32'((s << 1) | 1));
            repeat (20) @(posedge aclk);
            check(32'(period), 32'(2 << (s - 1)));
        end
        pll_en <= 1'b0;
        repeat (4) @(posedge aclk);
        n0 = rises;
        repeat (20) @(posedge aclk);
        check(32'(rises), 32'(n0));
        check(32'(flags[2]), 32'h0);
        pll_en <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic t_power_down();
        logic [15:0] n0;
        int          hi;
        hi = 0;
        pd <= 1'b1;
        repeat (3) @(posedge aclk);
        n0 = rises;
        repeat (16) begin
            @(posedge aclk);
            if (ref_out !== 1'b0) hi++;
        end
        check(32'(hi), 32'h0);
        check(32'(rises), 32'(n0));
        pd <= 1'b0;
        @(posedge aclk);
    endtask

    // mid-run reset with both strap bits low: pin carries flag c
    task automatic t_strap_off();
        int hi;
        strap   <= 2'h0;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(`ORC_OFF_STATE, 32'h2, `ORC_RESP_OKAY);
        pulse(2, 12'h801, hi);
        check(32'(hi), 32'h4);
    endtask

    initial begin
        fails      = 0;
        n_compared = 0;
        req        = '0;
        aresetn    = 1'b0;
        smp        = '{default: 12'h000};
        variant    = ORC_QUAD;
        // straps and pll held from power up, no register writes
        strap      = 2'h1;
        pll_en     = 1'b1;
        pd         = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (12) @(posedge aclk);
        t_strap_clock();
        t_regs_and_irq();
        t_variants();
        t_clock_select();
        t_power_down();
        t_strap_off();
        tally_and_finish();
    end
endmodule

/* File: src/orc_pkg.sv */
// types of the over-range flag and clock output block
package orc_pkg;

    typedef enum logic [1:0] {ORC_SINGLE, ORC_DUAL, ORC_QUAD} orc_variant_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } orc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } orc_axi_rsp_t;

    typedef struct packed {
        logic [11:0]     thresh;
        logic [7:0]      plen;
        logic            ovr_en;
        logic [1:0]      ovr_sel;
        logic [2:0]      sts;
        logic [2:0]      mask;
        logic            strap_ok;
        logic [1:0]      strap_sel;
        logic [1:0]      sel;
        logic            clk_mode;
        logic [2:0]      flag;
        logic [2:0][7:0] cnt;
        logic            ref_clk;
        logic            div2;
        logic            div4;
        logic            c_out;
        logic            aw_got;
        logic            w_got;
        logic [7:0]      awaddr;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } orc_state_t;

endpackage

/* File: src/orc_regs.svh */
// register offsets, field positions and reset values of the over-range block
`ifndef ORC_REGS_SVH
`define ORC_REGS_SVH

`define ORC_CLK_PERIOD_NS 8
`define ORC_ADDR_W        8
`define ORC_OFF_THRESH    8'h00
`define ORC_OFF_PLEN      8'h04
`define ORC_OFF_CLKCTL    8'h08
`define ORC_OFF_STATUS    8'h0c
`define ORC_OFF_MASK      8'h10
`define ORC_OFF_STATE     8'h14

`define ORC_CLKCTL_OVR_BIT 0
`define ORC_CLKCTL_SEL_LSB 1
`define ORC_CLKCTL_SEL_MSB 2

`define ORC_THRESH_RST    12'h700
`define ORC_PLEN_RST      8'h04

`define ORC_CSEL_OFF      2'h0
`define ORC_CSEL_FULL     2'h1
`define ORC_CSEL_DIV2     2'h2
`define ORC_CSEL_DIV4     2'h3

`define ORC_RESP_OKAY     2'h0
`define ORC_RESP_SLVERR   2'h2

`endif

/* File: src/orc_top.sv */
// over-range flags, channel c clock mux and axi4-lite register slave
//
// Operation
// - flag high while input exceeds threshold
// - flag holds at least programmed pulse length
// - channel b flag unused on single variant
// - channel c detection only on quad variant
// - channel c clock when selected and pll on
// - channel c carries flag when clock deselected
// - select 1 full, 2 half, 3 quarter rate
// - strapped clock appears without register writes
// - power down stops reference and clock outputs
`timescale 1ns/10ps
`include "orc_regs.svh"

module orc_top
    import orc_pkg::*;
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // register bus
    input  wire orc_axi_req_t axi_req,
    output orc_axi_rsp_t      axi_rsp,
    // converter samples, signed
    input  wire logic [11:0]  sample_a,
    input  wire logic [11:0]  sample_b,
    input  wire logic [11:0]  sample_c,
    // straps and control pins
    input  wire orc_variant_t device_variant,
    input  wire logic [1:0]   clock_out_select,
    input  wire logic         pll_enable,
    input  wire logic         power_down_pin,
    // status and clock outputs
    output logic              overrange_flag_ch_a,
    output logic              overrange_flag_ch_b,
    output logic              overrange_flag_ch_c_or_clock,
    output logic              pll_reference_output,
    output logic              irq
);

    orc_state_t       s_q;
    orc_state_t       s_d;
    logic [2:0][11:0] sample;
    logic [2:0]       exc;
    logic [2:0]       rclr;
    logic [1:0]       eff_sel;
    logic             pll_on;
    logic             extra_clock_out_c;
    logic [31:0]      rd_val;
    logic             rd_ok;

    // magnitude of a signed sample; -2048 gives 0x800, above any threshold below 0x800
    function automatic logic [11:0] mag(input logic [11:0] s);
        mag = s[11] ? 12'((~s) + 12'h001) : s;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    function automatic logic pick_clk(input logic [1:0] sel,
                                      input logic       r,
                                      input logic       d2,
                                      input logic       d4);
        case (sel)
            `ORC_CSEL_FULL: pick_clk = r;
            `ORC_CSEL_DIV2: pick_clk = d2;
            `ORC_CSEL_DIV4: pick_clk = d4;
            default:        pick_clk = 1'b0;
        endcase
    endfunction

    assign sample = {sample_c, sample_b, sample_a};

    // channel a always, b on dual and quad, c on quad only
    always_comb begin
        exc[0] = mag(sample[0]) > s_q.thresh;
        exc[1] = (device_variant != ORC_SINGLE)
                 && (mag(sample[1]) > s_q.thresh);
        exc[2] = (device_variant == ORC_QUAD)
                 && (mag(sample[2]) > s_q.thresh);
    end

    // the strap decides until software sets the override bit
    assign eff_sel = s_q.ovr_en ? s_q.ovr_sel : s_q.strap_sel;
    assign pll_on  = pll_enable && !power_down_pin;

    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (axi_req.araddr)
            `ORC_OFF_THRESH: rd_val = {20'h0_0000, s_q.thresh};
            `ORC_OFF_PLEN:   rd_val = {24'h00_0000, s_q.plen};
            `ORC_OFF_CLKCTL: rd_val = {29'h0000_0000, s_q.ovr_sel,
                                       s_q.ovr_en};
            `ORC_OFF_STATUS: rd_val = {29'h0000_0000, s_q.sts};
            `ORC_OFF_MASK:   rd_val = {29'h0000_0000, s_q.mask};
            `ORC_OFF_STATE:  rd_val = {22'h00_0000, s_q.flag,
                                       s_q.clk_mode, s_q.sel,
                                       s_q.strap_sel, device_variant};
            default:         rd_ok  = 1'b0;
        endcase
    end

    always_comb begin
        s_d  = s_q;
        rclr = 3'h0;

        // straps are caught once, on the first edge after reset release
        if (!s_q.strap_ok) begin
            s_d.strap_ok  = 1'b1;
            s_d.strap_sel = clock_out_select;
        end

        s_d.sel      = eff_sel;
        s_d.clk_mode = pll_on && s_q.strap_ok
                       && (eff_sel != `ORC_CSEL_OFF);

        // reference toggles every cycle; dividers follow its rising edges
        if (!pll_on) begin
            s_d.ref_clk = 1'b0;
            s_d.div2    = 1'b0;
            s_d.div4    = 1'b0;
        end else begin
            s_d.ref_clk = !s_q.ref_clk;
            if (!s_q.ref_clk) begin
                s_d.div2 = !s_q.div2;
            end
            if (!s_q.ref_clk && !s_q.div2) begin
                s_d.div4 = !s_q.div4;
            end
        end

        // a zero pulse length still gives a one-cycle flag
        for (int i = 0; i < 3; i++) begin
            if (exc[i]) begin
                s_d.flag[i] = 1'b1;
                s_d.cnt[i]  = (s_q.plen == 8'h00) ? 8'h00
                              : 8'(s_q.plen - 8'h01);
            end else if (s_q.cnt[i] != 8'h00) begin
                s_d.flag[i] = 1'b1;
                s_d.cnt[i]  = 8'(s_q.cnt[i] - 8'h01);
            end else begin
                s_d.flag[i] = 1'b0;
            end
        end

        extra_clock_out_c = pick_clk(s_d.sel, s_d.ref_clk, s_d.div2,
                                     s_d.div4);
        s_d.c_out = s_d.clk_mode ? extra_clock_out_c
                                 : s_d.flag[2];

        // write channel: address and data in either order
        if (axi_req.awvalid && !s_q.aw_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_q.w_got && !s_q.bvalid) begin
            s_d.w_got = 1'b1;
            s_d.wdata = axi_req.wdata;
            s_d.wstrb = axi_req.wstrb;
        end
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = `ORC_RESP_OKAY;
            case (s_q.awaddr)
                `ORC_OFF_THRESH: s_d.thresh = 12'(merge(
                    {20'h0_0000, s_q.thresh}, s_q.wdata, s_q.wstrb));
                `ORC_OFF_PLEN: s_d.plen = 8'(merge(
                    {24'h00_0000, s_q.plen}, s_q.wdata, s_q.wstrb));
                `ORC_OFF_CLKCTL: begin
                    if (s_q.wstrb[0]) begin
                        s_d.ovr_en  = s_q.wdata[`ORC_CLKCTL_OVR_BIT];
                        s_d.ovr_sel = s_q.wdata[`ORC_CLKCTL_SEL_MSB:
                                                `ORC_CLKCTL_SEL_LSB];
                    end
                end
                `ORC_OFF_MASK: begin
                    if (s_q.wstrb[0]) begin
                        s_d.mask = s_q.wdata[2:0];
                    end
                end
                `ORC_OFF_STATUS, `ORC_OFF_STATE: ;
                default: s_d.bresp = `ORC_RESP_SLVERR;
            endcase
        end else if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end

        // read channel: one outstanding read, status clears on read
        if (axi_req.arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_val;
            s_d.rresp  = rd_ok ? `ORC_RESP_OKAY : `ORC_RESP_SLVERR;
            if (axi_req.araddr == `ORC_OFF_STATUS) begin
                rclr = s_q.sts;
            end
        end else if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end

        // a new event in the clearing cycle stays set
        s_d.sts = (s_q.sts & ~rclr) | exc;
    end

    // reset also re-arms the strap capture, so new straps count after it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q        <= '0;
            s_q.thresh <= `ORC_THRESH_RST;
            s_q.plen   <= `ORC_PLEN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // readies come from flops only, so no path from valid back to ready
    assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
    assign axi_rsp.wready  = !s_q.w_got && !s_q.bvalid;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;

    assign overrange_flag_ch_a          = s_q.flag[0];
    assign overrange_flag_ch_b          = s_q.flag[1];
    assign overrange_flag_ch_c_or_clock = s_q.c_out;
    assign pll_reference_output         = s_q.ref_clk;
    // level interrupt straight from the status and mask flops
    assign irq                          = |(s_q.sts & s_q.mask);

    // all checks run on the bus clock and sleep through reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    thresh_sets_a: assert property (exc[0] |=> overrange_flag_ch_a)
        else $error("flag a missing after threshold crossing");
    pulse_holds_a: assert property ($rose(overrange_flag_ch_a)
        && s_q.plen >= 8'h03 && !exc[0] |=> overrange_flag_ch_a [*2])
        else $error("flag a pulse shorter than programmed");
    single_b_off_a: assert property (device_variant == ORC_SINGLE
        ##1 device_variant == ORC_SINGLE [*8] |-> !overrange_flag_ch_b)
        else $error("flag b active on single variant");
    quad_only_c_a: assert property (device_variant != ORC_QUAD
        |=> !s_q.flag[2])
        else $error("channel c detection off quad variant");
    clock_needs_pll_a: assert property (s_q.clk_mode
        |-> $past(pll_enable) && !$past(power_down_pin))
        else $error("clock mode without pll enabled");
    flag_path_c_a: assert property (!s_q.clk_mode
        |-> overrange_flag_ch_c_or_clock == s_q.flag[2])
        else $error("channel c output not carrying its flag");
    full_rate_c_a: assert property (s_q.clk_mode
        && s_q.sel == `ORC_CSEL_FULL
        |-> overrange_flag_ch_c_or_clock == pll_reference_output)
        else $error("full rate clock differs from reference");
    quarter_rate_a: assert property (s_q.clk_mode && s_q.sel
        == `ORC_CSEL_DIV4 && $rose(overrange_flag_ch_c_or_clock)
        ##1 (s_q.clk_mode && s_q.sel == `ORC_CSEL_DIV4) [*3]
        |-> overrange_flag_ch_c_or_clock)
        else $error("quarter rate clock high phase too short");
    power_down_a: assert property (power_down_pin
        |=> !pll_reference_output && !s_q.clk_mode)
        else $error("clocks running in power down");
    flag_release_a: assert property (s_q.flag[0] && s_q.cnt[0] == 8'h00
        && !exc[0] |=> !overrange_flag_ch_a)
        else $error("flag a held past its pulse");

    // a read that clears status must never hide an event of the same cycle
    status_sets_a: assert property (exc[0] |=> s_q.sts[0])
        else $error("status bit a lost on a new event");
    status_clear_a: assert property (rclr[1] && !exc[1]
        |=> !s_q.sts[1])
        else $error("status bit b not cleared by read");
    flag_b_sets_a: assert property (exc[1] |=> overrange_flag_ch_b)
        else $error("flag b missing after threshold crossing");
    flag_c_sets_a: assert property (exc[2] |=> s_q.flag[2])
        else $error("flag c missing after threshold crossing");

    over_a_c: cover property ($rose(overrange_flag_ch_a)
        ##[1:20] $fell(overrange_flag_ch_a));
    div2_c: cover property (s_q.clk_mode && s_q.sel == `ORC_CSEL_DIV2);
    status_clear_c: cover property (s_q.sts != 3'h0 && rclr != 3'h0);
    // clock from the straps alone, and the slowest rate
    strap_clk_c: cover property (s_q.clk_mode && !s_q.ovr_en);
    div4_c: cover property (s_q.clk_mode && s_q.sel == `ORC_CSEL_DIV4);

endmodule
